// File: rtl/sse_pkg.sv
// Package of types and constants for the skip and subtract execution block.
package sse_pkg;

  localparam int unsigned SSE_DATA_W = 8;
  localparam int unsigned SSE_ADDR_W = 8;
  localparam int unsigned SSE_BIT_W  = 3;

  localparam logic [SSE_DATA_W-1:0] SSE_ACC_RST  = 8'h00;
  localparam logic [SSE_DATA_W-1:0] SSE_ZERO     = 8'h00;
  localparam logic [SSE_DATA_W-1:0] SSE_ONE      = 8'h01;
  localparam logic [3:0]            SSE_NIB_ZERO = 4'h0;

  typedef enum logic [2:0] {
    SSE_OP_SKIP_BIT_NONNULL = 3'h0,
    SSE_OP_SKIP_NONNULL     = 3'h1,
    SSE_OP_SUB_WORKING      = 3'h2,
    SSE_OP_SUB_MEMORY       = 3'h3,
    SSE_OP_INC_WORK_SKIP    = 3'h4
  } sse_op_t;

  typedef struct packed {
    sse_op_t               op;
    logic [SSE_ADDR_W-1:0] addr;
    logic [SSE_BIT_W-1:0]  bit_sel;
  } sse_cmd_t;

  typedef struct packed {
    logic signed_range_exceeded_flag;
    logic zero_flag;
    logic nibble_borrow_flag;
    logic carry_flag;
    logic signed_borrow_flag;
    logic multi_byte_nil_flag;
  } sse_flags_t;

  localparam sse_flags_t SSE_FLAGS_RST = 6'h00;

endpackage

// File: rtl/sse_alu.sv
// Combinational subtract and increment datapath with flag generation.
`timescale 1ns/1ps
module sse_alu (
  input  wire logic [7:0]          i_acc,
  input  wire logic [7:0]          i_mem,
  output logic      [7:0]          o_diff,
  output sse_pkg::sse_flags_t      o_sub_flags,
  output logic      [7:0]          o_inc
);

  logic [8:0] wide_diff;
  logic [4:0] nib_diff;
  logic       ovf;

  always_comb begin
    wide_diff = {1'b0, i_acc} - {1'b0, i_mem};
    nib_diff  = {1'b0, i_acc[3:0]} - {1'b0, i_mem[3:0]};
    ovf       = (i_acc[7] ^ i_mem[7]) & (i_acc[7] ^ wide_diff[7]);
    o_diff    = wide_diff[7:0];
    o_inc     = i_mem + sse_pkg::SSE_ONE;
    o_sub_flags.signed_range_exceeded_flag = ovf;
    o_sub_flags.zero_flag = (wide_diff[7:0] == sse_pkg::SSE_ZERO);
    // A borrow out of either width means a negative difference there.
    o_sub_flags.nibble_borrow_flag = ~nib_diff[4];
    o_sub_flags.carry_flag         = ~wide_diff[8];
    // The true sign survives an overflow, so it is result sign xor overflow.
    o_sub_flags.signed_borrow_flag  = wide_diff[7] ^ ovf;
    o_sub_flags.multi_byte_nil_flag = (wide_diff[7:0] == sse_pkg::SSE_ZERO);
  end

endmodule

// File: rtl/sse_exec.sv
// Execution sequencer for the skip, subtract and increment-skip group.
`timescale 1ns/1ps
module sse_exec #(
  parameter int unsigned ADDR_W = sse_pkg::SSE_ADDR_W
) (
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  input  wire logic                i_enable,
  input  wire logic                i_start,
  input  wire sse_pkg::sse_cmd_t   i_cmd,
  input  wire logic                i_acc_load,
  input  wire logic [7:0]          i_acc_wdata,
  input  wire logic [7:0]          i_mem_rdata,
  output logic      [ADDR_W-1:0]   o_mem_addr,
  output logic                     o_mem_rd,
  output logic                     o_mem_wr,
  output logic      [7:0]          o_mem_wdata,
  output logic      [7:0]          o_acc,
  output sse_pkg::sse_flags_t      o_flags,
  output logic                     o_busy,
  output logic                     o_done,
  output logic                     o_skip,
  output logic                     o_discard
);

  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    SSE_ST_IDLE  = 2'h0,
    SSE_ST_READ  = 2'h1,
    SSE_ST_EXEC  = 2'h3,
    SSE_ST_DUMMY = 2'h2
  } sse_state_t;

  sse_state_t          state_r;
  sse_state_t          state_nxt;
  sse_pkg::sse_op_t    op_r;
  logic [2:0]          bit_r;
  logic [7:0]          mem_r;
  logic [7:0]          diff;
  logic [7:0]          inc;
  sse_pkg::sse_flags_t sub_flags;
  logic                is_skip_op;
  logic                skip_cond;

  sse_alu u_alu (
    .i_acc       (o_acc),
    .i_mem       (mem_r),
    .o_diff      (diff),
    .o_sub_flags (sub_flags),
    .o_inc       (inc)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    is_skip_op = (op_r == sse_pkg::SSE_OP_SKIP_BIT_NONNULL) ||
                 (op_r == sse_pkg::SSE_OP_SKIP_NONNULL) ||
                 (op_r == sse_pkg::SSE_OP_INC_WORK_SKIP);
    case (op_r)
      sse_pkg::SSE_OP_SKIP_BIT_NONNULL: begin
        skip_cond = mem_r[bit_r];
      end
      sse_pkg::SSE_OP_SKIP_NONNULL: begin
        skip_cond = (mem_r != sse_pkg::SSE_ZERO);
      end
      sse_pkg::SSE_OP_INC_WORK_SKIP: begin
        skip_cond = (inc == sse_pkg::SSE_ZERO);
      end
      default: begin
        skip_cond = 1'b0;
      end
    endcase
  end

  // Skips always pass through the dummy cycle so their length is fixed.
  always_comb begin
    case (state_r)
      SSE_ST_IDLE: begin
        state_nxt = i_start ? SSE_ST_READ : SSE_ST_IDLE;
      end
      SSE_ST_READ: begin
        state_nxt = SSE_ST_EXEC;
      end
      SSE_ST_EXEC: begin
        state_nxt = is_skip_op ? SSE_ST_DUMMY : SSE_ST_IDLE;
      end
      SSE_ST_DUMMY: begin
        state_nxt = SSE_ST_IDLE;
      end
      default: begin
        state_nxt = SSE_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r <= SSE_ST_IDLE;
    end else if (i_enable) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      op_r       <= sse_pkg::SSE_OP_SKIP_BIT_NONNULL;
      bit_r      <= 3'h0;
      o_mem_addr <= '0;
    end else if (i_enable && state_r == SSE_ST_IDLE && i_start) begin
      op_r       <= i_cmd.op;
      bit_r      <= i_cmd.bit_sel;
      o_mem_addr <= i_cmd.addr[ADDR_W-1:0];
    end
  end

  // Memory answers in the same cycle as the read strobe.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_mem_rd <= 1'b0;
    end else if (i_enable) begin
      o_mem_rd <= (state_nxt == SSE_ST_READ);
    end
  end

  // The byte is latched once, so later bus traffic cannot move the result.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      mem_r <= sse_pkg::SSE_ZERO;
    end else if (i_enable && state_r == SSE_ST_READ) begin
      mem_r <= i_mem_rdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_mem_wr    <= 1'b0;
      o_mem_wdata <= sse_pkg::SSE_ZERO;
    end else if (i_enable) begin
      o_mem_wr <= 1'b0;
      if (state_r == SSE_ST_EXEC) begin
        if (op_r == sse_pkg::SSE_OP_SKIP_NONNULL) begin
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= mem_r;
        end else if (op_r == sse_pkg::SSE_OP_SUB_MEMORY) begin
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= diff;
        end
      end
    end
  end

  // A load from the sequencer while busy would race the result, so it is taken only in the idle state and dropped otherwise.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_acc <= sse_pkg::SSE_ACC_RST;
    end else if (i_enable) begin
      if (state_r == SSE_ST_EXEC) begin
        if (op_r == sse_pkg::SSE_OP_SUB_WORKING) begin
          o_acc <= diff;
        end else if (op_r == sse_pkg::SSE_OP_INC_WORK_SKIP) begin
          o_acc <= inc;
        end
      end else if (state_r == SSE_ST_IDLE && i_acc_load) begin
        o_acc <= i_acc_wdata;
      end
    end
  end

  // Flags move only on subtracts; every other command leaves them standing.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_flags <= sse_pkg::SSE_FLAGS_RST;
    end else if (i_enable && state_r == SSE_ST_EXEC &&
                 (op_r == sse_pkg::SSE_OP_SUB_WORKING ||
                  op_r == sse_pkg::SSE_OP_SUB_MEMORY)) begin
      o_flags <= sub_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_enable) begin
      o_busy <= (state_nxt != SSE_ST_IDLE);
      o_done <= (state_r != SSE_ST_IDLE) && (state_nxt == SSE_ST_IDLE);
    end
  end

  // Skip stands through the first idle cycle so the sequencer may read it late.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_skip    <= 1'b0;
      o_discard <= 1'b0;
    end else if (i_enable) begin
      if (state_r == SSE_ST_EXEC) begin
        o_skip <= is_skip_op && skip_cond;
      end else if (state_r == SSE_ST_IDLE) begin
        o_skip <= 1'b0;
      end
      // Only the dummy cycle kills the prefetched word; skip rises with it and the SSE_OP_SKIP_NONNULL write-back lands there.
      o_discard <= (state_r == SSE_ST_EXEC) &&
                   is_skip_op && skip_cond;
    end
  end

endmodule

// File: verification/sse_memory_model.sv
// Data memory model behind the execution block, with a combinational read.
`timescale 1ns/1ps
module sse_memory_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_rd,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  // Unselected lines show the inverse of the last byte so stale data fails.
  assign o_rdata = i_rd ? mem[i_addr] : ~last_r;
  always @(posedge i_clock) begin
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_rd) begin
      last_r <= mem[i_addr];
    end
  end
endmodule

// File: verification/sse_exec_monitor.sv
// Port checks for the skip and subtract execution block.
`timescale 1ns/1ps
module sse_exec_monitor #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic                i_clock,
  input wire logic                i_reset,
  input wire logic                i_enable,
  input wire logic                i_start,
  input wire sse_pkg::sse_cmd_t   i_cmd,
  input wire logic [7:0]          i_mem_rdata,
  input wire logic [ADDR_W-1:0]   o_mem_addr,
  input wire logic                o_mem_rd,
  input wire logic                o_mem_wr,
  input wire logic [7:0]          o_mem_wdata,
  input wire logic [7:0]          o_acc,
  input wire sse_pkg::sse_flags_t o_flags,
  input wire logic                o_busy,
  input wire logic                o_done,
  input wire logic                o_skip,
  input wire logic                o_discard
);
  logic       take;
  logic [2:0] op_r;
  logic [2:0] bit_r;
  logic [7:0] rd_r;
  assign take = i_enable && i_start && !o_busy;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      op_r  <= 3'h0;
      bit_r <= 3'h0;
    end else if (take) begin
      op_r  <= i_cmd.op;
      bit_r <= i_cmd.bit_sel;
    end
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rd_r <= 8'h00;
    end else if (o_mem_rd) begin
      rd_r <= i_mem_rdata;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_start_reads: assert property (
    take |=> o_busy && o_mem_rd && o_mem_addr == $past(i_cmd.addr))
    else $error("no read after start");
  a_sub_two: assert property (
    take && i_cmd.op inside {3'h2, 3'h3} ##1 i_enable [*2]
    |-> ##1 o_done && !o_busy)
    else $error("subtract length wrong");
  a_skip_three: assert property (
    take && i_cmd.op inside {3'h0, 3'h1, 3'h4} ##1 i_enable [*3]
    |-> ##1 o_done && o_flags == $past(o_flags, 4)) else $error("skip wrong");
  a_sub_working: assert property (
    o_done && op_r == 3'h2 |-> o_acc == 8'($past(o_acc) - rd_r)
    && o_flags.carry_flag == ($past(o_acc) >= rd_r)) else $error("sub acc");
  a_sub_memory: assert property (
    o_mem_wr && op_r == 3'h3 |-> o_done && o_mem_wdata == 8'(o_acc - rd_r)
    && o_flags.carry_flag == (o_acc >= rd_r)) else $error("sub mem");
  a_zero_flag: assert property (
    o_done && op_r inside {3'h2, 3'h3}
    |-> o_flags.zero_flag == ($past(o_acc) == rd_r)) else $error("zero");
  a_bit_skip: assert property (
    o_done && op_r == 3'h0 |-> o_skip == rd_r[bit_r]) else $error("bit skip");
  a_byte_skip: assert property (
    o_done && op_r == 3'h1 |-> o_skip == (rd_r != 8'h00) && $past(o_mem_wr)
    && o_mem_wdata == rd_r) else $error("byte skip");
  a_inc_skip: assert property (
    o_done && op_r == 3'h4 |-> o_acc == 8'(rd_r + 8'h01) && !$past(o_mem_wr)
    && o_skip == (o_acc == 8'h00)) else $error("inc skip");
  a_discard_tie: assert property (
    o_done && op_r inside {3'h0, 3'h1, 3'h4} |-> $past(o_discard) == o_skip)
    else $error("discard");
  c_skip_taken: cover property (o_done && o_skip);
  c_mem_write: cover property (o_mem_wr);
  c_sub_mem: cover property (o_done && op_r == 3'h3);
  c_stall_run: cover property (o_busy && !i_enable);
endmodule

// File: verification/sse_exec_bench.sv
// Self-checking bench for the skip and subtract execution block.
`timescale 1ns/1ps
module sse_exec_bench;
  logic                i_clock, i_reset, i_enable, i_start, i_acc_load;
  logic [7:0]          i_acc_wdata, i_mem_rdata, o_mem_addr, o_mem_wdata;
  logic [7:0]          o_acc;
  logic                o_mem_rd, o_mem_wr, o_busy, o_done, o_skip, o_discard;
  sse_pkg::sse_cmd_t   i_cmd;
  sse_pkg::sse_flags_t o_flags, f;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  sse_exec DUT (.i_clock, .i_reset, .i_enable, .i_start, .i_cmd, .i_acc_load,
    .i_acc_wdata, .i_mem_rdata, .o_mem_addr, .o_mem_rd, .o_mem_wr,
    .o_mem_wdata, .o_acc, .o_flags, .o_busy, .o_done, .o_skip, .o_discard);
  sse_memory_model u_mem (.i_clock, .i_addr(o_mem_addr), .i_rd(o_mem_rd),
    .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic ld(input logic [7:0] v);
    @(posedge i_clock);
    i_acc_load  <= 1'b1;
    i_acc_wdata <= v;
    @(posedge i_clock);
    i_acc_load <= 1'b0;
  endtask
  // Returns in the done cycle, so skip and flags are read while they stand.
  task automatic run(input logic [2:0] op, input logic [7:0] a,
                     input logic [2:0] b, input int n);
    int c;
    @(posedge i_clock);
    i_start <= 1'b1;
    i_cmd   <= {op, a, b};
    @(posedge i_clock);
    i_start <= 1'b0;
    c = 0;
    do begin
      @(posedge i_clock);
      #1;
      c++;
    end while (o_done !== 1'b1 && c < 9);
    chk("cycles", 8'(n), 8'(c));
  endtask
  task automatic t_sub;
    ld(8'h10);
    u_mem.mem[8'h20] = 8'h30;
    run(3'h2, 8'h20, 3'h0, 2);
    chk("acc", 8'he0, o_acc);
    chk("carry", 8'h00, 8'(o_flags.carry_flag));
    chk("flags", 8'h0a, 8'(o_flags));
    u_mem.mem[8'h21] = 8'he0;
    run(3'h3, 8'h21, 3'h0, 2);
    chk("carry", 8'h01, 8'(o_flags.carry_flag));
    chk("zero", 8'h01, 8'(o_flags.zero_flag));
    chk("flags", 8'h1d, 8'(o_flags));
    @(posedge i_clock);
    #1;
    chk("mem", 8'h00, u_mem.mem[8'h21]);
    chk("acc", 8'he0, o_acc);
    ld(8'h80);
    u_mem.mem[8'h22] = 8'h01;
    run(3'h2, 8'h22, 3'h0, 2);
    chk("acc", 8'h7f, o_acc);
    chk("flags", 8'h26, 8'(o_flags));
    $display("subtract test ended");
  endtask
  task automatic t_skip;
    f = o_flags;
    u_mem.mem[8'h30] = 8'h80;
    u_mem.mem[8'h31] = 8'h00;
    u_mem.mem[8'h32] = 8'h01;
    run(3'h0, 8'h30, 3'h7, 3);
    chk("skip", 8'h01, 8'(o_skip));
    run(3'h0, 8'h30, 3'h6, 3);
    chk("skip", 8'h00, 8'(o_skip));
    run(3'h1, 8'h31, 3'h0, 3);
    chk("skip", 8'h00, 8'(o_skip));
    run(3'h1, 8'h32, 3'h0, 3);
    chk("skip", 8'h01, 8'(o_skip));
    chk("flags", 8'(f), 8'(o_flags));
    $display("skip test ended");
  endtask
  task automatic t_inc;
    u_mem.mem[8'h40] = 8'hff;
    run(3'h4, 8'h40, 3'h0, 3);
    chk("acc", 8'h00, o_acc);
    chk("skip", 8'h01, 8'(o_skip));
    u_mem.mem[8'h41] = 8'h41;
    run(3'h4, 8'h41, 3'h0, 3);
    chk("acc", 8'h42, o_acc);
    chk("skip", 8'h00, 8'(o_skip));
    chk("mem", 8'hff, u_mem.mem[8'h40]);
    $display("increment test ended");
  endtask
  // Enable drops for three edges just after the command is taken.
  task automatic t_stall;
    ld(8'h05);
    u_mem.mem[8'h50] = 8'h03;
    fork
      begin
        @(posedge i_clock);
        @(posedge i_clock);
        i_enable <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_enable <= 1'b1;
      end
    join_none
    run(3'h2, 8'h50, 3'h0, 5);
    chk("acc", 8'h02, o_acc);
    f = o_flags;
    run(3'h5, 8'h50, 3'h0, 2);
    chk("acc", 8'h02, o_acc);
    chk("flags", 8'(f), 8'(o_flags));
    $display("stall test ended");
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
  initial begin
    i_reset     = 1'b1;
    i_enable    = 1'b1;
    i_start     = 1'b0;
    i_cmd       = '0;
    i_acc_load  = 1'b0;
    i_acc_wdata = 8'h00;
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    t_sub;
    t_skip;
    t_inc;
    t_stall;
    end_of_test;
  end
endmodule
bind sse_exec sse_exec_monitor #(.ADDR_W(ADDR_W)) u_mon (.i_clock, .i_reset,
  .i_enable, .i_start, .i_cmd, .i_mem_rdata, .o_mem_addr, .o_mem_rd, .o_mem_wr,
  .o_mem_wdata, .o_acc, .o_flags, .o_busy, .o_done, .o_skip, .o_discard);
